// file: ccio_pkg.sv
/*
 * Shared constants and types for the compare/capture channel
 * input conditioning and output action logic.
 * Assumes a single clock domain and a word-wide control register.
 */
package ccio_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int          CCIO_ADDR_W     = 8;
   localparam int          CCIO_DATA_W     = 32;
   localparam logic [7:0]  CCIO_CTRL_OFS   = 8'h30;
   localparam logic [31:0] CCIO_CTRL_RST   = 32'h0000_0000;
   // Writable bits; unused bits 2, 4, 26 and 27 also store, other reserved positions always store and read zero
   localparam logic [31:0] CCIO_CTRL_WMASK = 32'h0f37_3f17;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CCIO_EDGE_LSB  = 24;
   localparam int CCIO_INPUT_FILTER_ENABLE_BIT  = 21;
   localparam int CCIO_INPUT_SOURCE_SELECT_BIT = 20;
   localparam int CCIO_EVSEL_LSB = 16;
   localparam int CCIO_EVSEL_W   = 3;
   localparam int CCIO_UF_LSB    = 12;
   localparam int CCIO_OF_LSB    = 10;
   localparam int CCIO_MA_LSB    = 8;
   localparam int CCIO_MODE_LSB  = 0;
   localparam int CCIO_EVT_CH    = 8;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CCIO_INPUT_FILTER_ENABLE_CYCLES = 5;
   localparam int CCIO_FCNT_W      = 3;

   // ==========================================================
   // Field encodings
   // ==========================================================
   typedef enum logic [1:0]
   {
      CCIO_EDGE_RISING  = 2'h0,
      CCIO_EDGE_FALLING = 2'h1,
      CCIO_EDGE_BOTH    = 2'h2,
      CCIO_EDGE_NONE    = 2'h3
   } ccio_edge_t;

   typedef enum logic [1:0]
   {
      CCIO_ACT_NONE   = 2'h0,
      CCIO_ACT_TOGGLE = 2'h1,
      CCIO_ACT_CLEAR  = 2'h2,
      CCIO_ACT_SET    = 2'h3
   } ccio_act_t;

   typedef enum logic [1:0]
   {
      CCIO_MODE_OFF     = 2'h0,
      CCIO_MODE_CAPTURE = 2'h1,
      CCIO_MODE_COMPARE = 2'h2,
      CCIO_MODE_PWM     = 2'h3
   } ccio_mode_t;

endpackage : ccio_pkg

// file: ccio_cond_if.sv
/*
 * Carrier between the channel top and its input conditioner.
 * Assumes both ends share sys_clk.
 */
interface ccio_cond_if;
   import ccio_pkg::*;

   logic       sig_in;
   logic       input_filter_enable_en;
   logic [1:0] edge_sel;
   logic       edge_pulse;
   logic       level;

   modport drv
   (
      output sig_in,
      output input_filter_enable_en,
      output edge_sel,
      input  edge_pulse,
      input  level
   );

   modport cond
   (
      input  sig_in,
      input  input_filter_enable_en,
      input  edge_sel,
      output edge_pulse,
      output level
   );

endinterface : ccio_cond_if

// file: ccio_in_cond.sv
/*
 * Input conditioner: optional digital filter followed by the edge detector.
 * Assumes sig_in is synchronous to sys_clk.
 */
module ccio_in_cond
   import ccio_pkg::*;
#(
   parameter int INPUT_FILTER_ENABLE_CYCLES = CCIO_INPUT_FILTER_ENABLE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   ccio_cond_if.cond c
);

   logic [CCIO_FCNT_W-1:0] cnt_r;
   logic [CCIO_FCNT_W-1:0] cnt_nxt;
   logic                   input_filter_enable_r;
   logic                   input_filter_enable_nxt;
   logic                   prev_r;
   logic                   prev_nxt;
   logic                   edge_r;
   logic                   edge_nxt;
   logic                   sel;

   // ==========================================================
   // Filter and edge detector
   // ==========================================================
   always_comb
   begin
      input_filter_enable_nxt = input_filter_enable_r;
      cnt_nxt  = '0;
      // A change must persist INPUT_FILTER_ENABLE_CYCLES clocks before it is accepted
      if (c.sig_in != input_filter_enable_r)
      begin
         if (cnt_r == CCIO_FCNT_W'(INPUT_FILTER_ENABLE_CYCLES - 1))
         begin
            input_filter_enable_nxt = c.sig_in;
         end
         else
         begin
            cnt_nxt = cnt_r + CCIO_FCNT_W'(1);
         end
      end
      sel      = c.input_filter_enable_en ? input_filter_enable_r : c.sig_in;
      prev_nxt = sel;
      case (c.edge_sel)
         CCIO_EDGE_RISING:  edge_nxt = sel & ~prev_r;
         CCIO_EDGE_FALLING: edge_nxt = ~sel & prev_r;
         CCIO_EDGE_BOTH:    edge_nxt = sel ^ prev_r;
         CCIO_EDGE_NONE:    edge_nxt = sel;
         default:           edge_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_r  <= '0;
         input_filter_enable_r <= 1'b0;
         prev_r <= 1'b0;
         edge_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         input_filter_enable_r <= input_filter_enable_nxt;
         prev_r <= prev_nxt;
         edge_r <= edge_nxt;
      end
   end

   assign c.edge_pulse = edge_r;
   assign c.level      = prev_r;

   // ==========================================================
   // Checks
   // ==========================================================
   AST_RISE_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!c.input_filter_enable_en && c.edge_sel == CCIO_EDGE_RISING && !prev_r && c.sig_in)
      |=> c.edge_pulse)
      else $error("Rising edge not reported");

   AST_NONE_PASS: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!c.input_filter_enable_en && c.edge_sel == CCIO_EDGE_NONE) |=> (c.edge_pulse == $past(c.sig_in)))
      else $error("Pass-through mode altered the input");

   AST_INPUT_FILTER_ENABLE_GLITCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (c.sig_in != input_filter_enable_r && cnt_r == '0) ##1 (c.sig_in == input_filter_enable_r) |=> $stable(input_filter_enable_r))
      else $error("One-cycle glitch passed the filter");

endmodule : ccio_in_cond

// file: ccio_channel.sv
/*
 * Compare/capture channel control: control register, input source
 * selection, conditioning and output actions on underflow, overflow
 * and compare match.
 * Assumes counter event inputs are one-cycle pulses on sys_clk and
 * that the pin and event channel inputs are synchronous to sys_clk.
 */
// Design decisions made here: the strobed register port and the address map.
// Operation
// - The edge field detects rising for 0, falling for 1, both for 2, and passes the input for 3.
// - The source bit picks the channel pin for 0 and the selected internal event channel for 1.
// - The three-bit event select field picks internal event channel N directly.
// - On underflow the output is kept, toggled, cleared or set for action 0 to 3.
// - On overflow the output is kept, toggled, cleared or set for action 0 to 3.
// - On compare match the output is kept, toggled or cleared for action 0 to 2.
// - On compare match with action 3 the output is set high.
// - The mode field selects off, input capture, output compare and PWM for 0 to 3.
module ccio_channel
   import ccio_pkg::*;
#(
   parameter int INPUT_FILTER_ENABLE_CYCLES = CCIO_INPUT_FILTER_ENABLE_CYCLES
)
(
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   input  wire logic [CCIO_ADDR_W-1:0]  bus_addr,
   input  wire logic [CCIO_DATA_W-1:0]  bus_wdata,
   input  wire logic                    bus_wr,
   input  wire logic                    bus_rd,
   output      logic [CCIO_DATA_W-1:0]  bus_rdata,
   input  wire logic                    channel_pin,
   input  wire logic [CCIO_EVT_CH-1:0]  internal_event_network,
   input  wire logic                    cnt_underflow,
   input  wire logic                    cnt_overflow,
   input  wire logic                    cmp_match,
   output      logic                    chan_out,
   output      logic                    edge_pulse,
   output      logic                    cond_level,
   output      logic [1:0]              chan_mode
);

   // ==========================================================
   // Output action decode
   // ==========================================================
   function automatic logic ccio_apply(input logic cur, input logic [1:0] act);
      case (act)
         CCIO_ACT_NONE:   ccio_apply = cur;
         CCIO_ACT_TOGGLE: ccio_apply = ~cur;
         CCIO_ACT_CLEAR:  ccio_apply = 1'b0;
         CCIO_ACT_SET:    ccio_apply = 1'b1;
         default:         ccio_apply = cur;
      endcase
   endfunction : ccio_apply

   logic [CCIO_DATA_W-1:0]  cc_channel_control_r;
   logic [CCIO_DATA_W-1:0]  cc_channel_control_nxt;
   logic [CCIO_DATA_W-1:0]  rdata_r;
   logic [CCIO_DATA_W-1:0]  rdata_nxt;
   logic                    out_r;
   logic                    out_nxt;
   logic [1:0]              capture_edge_select;
   logic                    input_filter_enable;
   logic                    input_source_select;
   logic [CCIO_EVSEL_W-1:0] event_channel_select;
   logic [1:0]              underflow_output_action;
   logic [1:0]              overflow_output_action;
   logic [1:0]              match_output_action;
   logic [1:0]              mode;
   logic                    ctrl_hit;
   logic                    drives_out;

   ccio_cond_if cond_bus ();

   assign capture_edge_select     = cc_channel_control_r[CCIO_EDGE_LSB +: 2];
   assign input_filter_enable     = cc_channel_control_r[CCIO_INPUT_FILTER_ENABLE_BIT];
   assign input_source_select     = cc_channel_control_r[CCIO_INPUT_SOURCE_SELECT_BIT];
   assign event_channel_select    = cc_channel_control_r[CCIO_EVSEL_LSB +: CCIO_EVSEL_W];
   assign underflow_output_action = cc_channel_control_r[CCIO_UF_LSB +: 2];
   assign overflow_output_action  = cc_channel_control_r[CCIO_OF_LSB +: 2];
   assign match_output_action     = cc_channel_control_r[CCIO_MA_LSB +: 2];
   assign mode                    = cc_channel_control_r[CCIO_MODE_LSB +: 2];
   assign ctrl_hit                = (bus_addr == CCIO_CTRL_OFS);

   // ==========================================================
   // Register port
   // ==========================================================
   always_comb
   begin
      cc_channel_control_nxt = cc_channel_control_r;
      rdata_nxt              = '0;
      if (bus_wr && ctrl_hit)
      begin
         // Reserved bits other than 2, 4, 26 and 27 are dropped even if software sets them
         cc_channel_control_nxt = bus_wdata & CCIO_CTRL_WMASK;
      end
      if (bus_rd && ctrl_hit)
      begin
         rdata_nxt = cc_channel_control_r;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cc_channel_control_r <= CCIO_CTRL_RST;
         rdata_r              <= '0;
      end
      else
      begin
         cc_channel_control_r <= cc_channel_control_nxt;
         rdata_r              <= rdata_nxt;
      end
   end

   // ==========================================================
   // Input source and conditioning
   // ==========================================================
   assign cond_bus.sig_in   = input_source_select ?
                              internal_event_network[event_channel_select]
                              : channel_pin;
   assign cond_bus.input_filter_enable_en  = input_filter_enable;
   assign cond_bus.edge_sel = capture_edge_select;

   ccio_in_cond #(
      .INPUT_FILTER_ENABLE_CYCLES (INPUT_FILTER_ENABLE_CYCLES)
   ) ccio_in_cond_inst (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .c       (cond_bus.cond)
   );

   // ==========================================================
   // Output actions
   // ==========================================================
   // Only compare and PWM modes drive the output; off holds it low
   assign drives_out = (mode == CCIO_MODE_COMPARE) || (mode == CCIO_MODE_PWM);

   always_comb
   begin
      out_nxt = out_r;
      if (mode == CCIO_MODE_OFF)
      begin
         out_nxt = 1'b0;
      end
      else if (drives_out)
      begin
         // Applied in sequence so a coincident match has the last word
         if (cnt_underflow)
         begin
            out_nxt = ccio_apply(out_nxt, underflow_output_action);
         end
         if (cnt_overflow)
         begin
            out_nxt = ccio_apply(out_nxt, overflow_output_action);
         end
         if (cmp_match)
         begin
            out_nxt = ccio_apply(out_nxt, match_output_action);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         out_r <= 1'b0;
      end
      else
      begin
         out_r <= out_nxt;
      end
   end

   assign bus_rdata  = rdata_r;
   assign chan_out   = out_r;
   assign edge_pulse = cond_bus.edge_pulse;
   assign cond_level = cond_bus.level;
   assign chan_mode  = mode;

   // ==========================================================
   // Checks
   // ==========================================================
   AST_MATCH_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cmp_match && match_output_action == CCIO_ACT_SET) |=> chan_out)
      else $error("Match with set action left output low");

   AST_MATCH_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cmp_match && match_output_action == CCIO_ACT_CLEAR) |=> !chan_out)
      else $error("Match with clear action left output high");

   AST_MATCH_TOGGLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cmp_match && !cnt_underflow && !cnt_overflow
       && match_output_action == CCIO_ACT_TOGGLE) |=> (chan_out != $past(chan_out)))
      else $error("Match with toggle action did not toggle");

   AST_UF_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cnt_underflow && !cnt_overflow && !cmp_match
       && underflow_output_action == CCIO_ACT_SET) |=> chan_out)
      else $error("Underflow with set action left output low");

   AST_OF_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cnt_overflow && !cmp_match
       && overflow_output_action == CCIO_ACT_CLEAR) |=> !chan_out)
      else $error("Overflow with clear action left output high");

   AST_OFF_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mode == CCIO_MODE_OFF) [*2] |-> !chan_out)
      else $error("Output high while channel off");

   AST_OF_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cnt_overflow && !cmp_match
       && overflow_output_action == CCIO_ACT_SET) |=> chan_out)
      else $error("Overflow with set action left output low");

   AST_UF_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (drives_out && cnt_underflow && !cnt_overflow && !cmp_match
       && underflow_output_action == CCIO_ACT_CLEAR) |=> !chan_out)
      else $error("Underflow with clear action left output high");

   AST_CAPTURE_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mode == CCIO_MODE_CAPTURE) [*2] |-> $stable(chan_out))
      else $error("Output changed while in capture mode");

endmodule : ccio_channel

// file: ccio_src_model.sv
/*
 * Far-side source model: the channel pin and the internal event channels.
 * Assumes the bench changes the selection and level just after an edge.
 */
module ccio_src_model
   import ccio_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   use_evt,
   input  wire logic [2:0]             evt_ch,
   input  wire logic                   lvl,
   output      logic                   channel_pin,
   output      logic [CCIO_EVT_CH-1:0] internal_event_network
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====
   // Sources
   logic tgl_r = 1'b0;

   // Unselected lines keep changing, so a wrong source pick shows as edges
   always @(posedge sys_clk)
   begin
      tgl_r <= ~tgl_r;
   end

   always_comb
   begin
      channel_pin            = use_evt ? tgl_r : lvl;
      internal_event_network = {CCIO_EVT_CH{tgl_r}};
      if (use_evt)
      begin
         internal_event_network[evt_ch] = lvl;
      end
   end
endmodule : ccio_src_model

// file: test_ccio_channel.sv
/*
 * Self-checking bench for the channel control block.
 * Assumes the source model stands on the input side.
 */
module test_ccio_channel;
   import ccio_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // =====
   // Signals
   localparam int FC = 3;
   logic                   sys_clk   = 1'b0;
   logic                   reset_n   = 1'b0;
   logic [7:0]             bus_addr  = 8'h00;
   logic [31:0]            bus_wdata = 32'h0;
   logic                   bus_wr    = 1'b0;
   logic                   bus_rd    = 1'b0;
   logic [31:0]            bus_rdata;
   logic                   channel_pin;
   logic [CCIO_EVT_CH-1:0] net;
   logic [2:0]             ev        = 3'h0;
   logic                   chan_out, edge_pulse, cond_level;
   logic [1:0]             chan_mode;
   logic                   use_evt   = 1'b0;
   logic [2:0]             evt_ch    = 3'h0;
   logic                   lvl       = 1'b0;
   int                     errors    = 0;
   int                     tests_run = 0;
   int                     cycles    = 0;
   logic [31:0]            x;
   int                     n;
   logic                   e1;

   always #5 sys_clk = ~sys_clk;

   ccio_channel #(.INPUT_FILTER_ENABLE_CYCLES(FC)) ccio_channel_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .channel_pin(channel_pin), .internal_event_network(net),
      .cnt_underflow(ev[0]), .cnt_overflow(ev[1]), .cmp_match(ev[2]),
      .chan_out(chan_out), .edge_pulse(edge_pulse), .cond_level(cond_level),
      .chan_mode(chan_mode));
   ccio_src_model ccio_src_model_inst (.sys_clk(sys_clk), .use_evt(use_evt),
      .evt_ch(evt_ch), .lvl(lvl), .channel_pin(channel_pin),
      .internal_event_network(net));

   // =====
   // Tasks
   task results;
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task chk(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task wr(logic [31:0] d, logic [7:0] a = CCIO_CTRL_OFS);
      @(posedge sys_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge sys_clk);
      bus_wr    <= 1'b0;
   endtask : wr

   task rd(output logic [31:0] d, input logic [7:0] a = CCIO_CTRL_OFS);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge sys_clk);
      bus_rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // Count edge pulses; a nonzero len restores the level after len cycles
   task drive(input logic v, input int len, output int cnt);
      cnt = 0;
      @(posedge sys_clk) lvl <= v;
      for (int i = 0; i < 10; i++)
      begin
         @(posedge sys_clk);
         if (i == len - 1)
            lvl <= ~v;
         #1 if (edge_pulse === 1'b1) cnt++;
      end
   endtask : drive

   task pulse(int k);
      @(posedge sys_clk) ev[k] <= 1'b1;
      @(posedge sys_clk) ev <= 3'h0;
      @(posedge sys_clk);
      #1;
   endtask : pulse

   function automatic logic act(int a, logic cur);
      return (a == 0) ? cur : (a == 1) ? ~cur : (a == 3);
   endfunction : act

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         results();
      end
   end

   // =====
   // Sequence
   initial
   begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(x);
      chk("ctrl reset", CCIO_CTRL_RST, x);
      wr(CCIO_CTRL_WMASK);
      rd(x);
      chk("ctrl mask", CCIO_CTRL_WMASK, x);
      @(posedge sys_clk);
      #1 chk("rdata idle", 32'h0, bus_rdata);
      wr(32'h0, 8'h34);
      rd(x, 8'h34);
      chk("unmapped", 32'h0, x);
      rd(x);
      chk("ctrl kept", CCIO_CTRL_WMASK, x);
      for (int e = 0; e < 4; e++)
      begin
         wr(32'(e) << CCIO_EDGE_LSB | 32'h1);
         drive(1'b1, 0, n);
         e1 = edge_pulse;
         chk("rise", (e == 3) ? 1 : (e == 0 || e == 2), (e == 3) ? e1 : n);
         chk("level", 1, cond_level);
         drive(1'b0, 0, n);
         e1 = edge_pulse;
         chk("fall", (e == 3) ? 0 : (e == 1 || e == 2), (e == 3) ? e1 : n);
      end
      wr(32'h0220_0001);
      drive(1'b1, FC - 1, n);
      chk("glitch filtered", 0, n);
      drive(1'b1, 0, n);
      chk("filtered edge", 1, n);
      wr(32'h0200_0001);
      drive(1'b0, 1, n);
      chk("glitch passed", 2, n);
      for (int c = 0; c < 8; c++)
      begin
         @(posedge sys_clk);
         use_evt <= 1'b1;
         evt_ch  <= 3'(c);
         lvl     <= 1'b0;
         wr(32'h0210_0001 | 32'(c) << CCIO_EVSEL_LSB);
         repeat (4) @(posedge sys_clk);
         drive(1'b1, 0, n);
         chk("event edge", 1, n);
      end
      for (int k = 0; k < 3; k++)
         for (int a = 0; a < 4; a++)
         begin
            wr(32'h0);
            repeat (2) @(posedge sys_clk);
            #1 chk("off", 0, chan_out);
            wr(32'(a) << (CCIO_MA_LSB + 2 * (2 - k)) | 32'(k ? 'h3000 : 'h0c00) | 32'h2);
            pulse(k ? 0 : 1);
            chk("preset", 1, chan_out);
            chk("mode", 2, chan_mode);
            pulse(k);
            e1 = act(a, 1'b1);
            chk("action 1", e1, chan_out);
            pulse(k);
            chk("action 2", act(a, e1), chan_out);
         end
      wr(32'h0c02);
      pulse(1);
      wr(32'h2001);
      pulse(0);
      chk("capture hold", 1, chan_out);
      chk("mode", 1, chan_mode);
      wr(32'h2003);
      pulse(0);
      chk("pwm clear", 0, chan_out);
      chk("mode", 3, chan_mode);
      results();
   end
endmodule : test_ccio_channel
